// ==== pkg/gpio_bank_regs.svh ====
`ifndef GPIO_BANK_REGS_SVH
`define GPIO_BANK_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_DIR0      12'h000
`define OFS_DIR1      12'h004
`define OFS_DIR2      12'h008
`define OFS_LAT0      12'h010
`define OFS_LAT1      12'h014
`define OFS_LAT2      12'h018
`define OFS_PIN0      12'h020
`define OFS_PIN1      12'h024
`define OFS_PIN2      12'h028
`define OFS_PULLUP    12'h030
`define OFS_PORTCTL   12'h034
`define OFS_MODE      12'h038
`define OFS_PERSEL0   12'h040
`define OFS_PERSEL1   12'h044
`define OFS_PERSEL2   12'h048

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define PORTCTL_RDLATCH_BIT 0
`define MODE_PROC_LSB       0
`define MODE_BUS8_BIT       2
`define MODE_MUXALL_BIT     3
`define RST_DIR             32'h0000_0000
`define RST_LAT             32'h0000_0000
`define RST_PULLUP          32'h0000_0000
`define RST_PORTCTL         32'h0000_0000
`define RST_MODE            32'h0000_0000

// ----------------------------------------------------------------------
// Pin map: 88 pins, port n at bits 8n..8n+7
// ----------------------------------------------------------------------
`define NUM_PINS            88
`define NUM_GROUPS          22
`define NMI_PIN_IDX         69
`define SECOND_PORT_LSB     8
`define BUSPORT_GROUP_MASK  22'h00_0DFF

`endif

// ==== pkg/gpio_bank_pkg.sv ====
package gpio_bank_pkg;

    // ------------------------------------------------------------------
    // Processor modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SINGLE_CHIP = 2'h0,
        MODE_MEM_EXPAND  = 2'h1,
        MODE_RESERVED    = 2'h2,
        MODE_MICRO       = 2'h3
    } proc_mode_t;

    // ------------------------------------------------------------------
    // Bus slave states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RESP = 2'h1,
        ST_DONE = 2'h3
    } bus_state_t;

endpackage : gpio_bank_pkg

// ==== src/gpio_pull_ctl.sv ====
`timescale 1ns/1ps
`include "gpio_bank_regs.svh"

module gpio_pull_ctl #(
    parameter int NPINS = `NUM_PINS,
    parameter int NGRP  = `NUM_GROUPS
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Settings
    input  wire logic [NGRP-1:0]  group_en,
    input  wire logic [NPINS-1:0] drive_en,
    input  wire logic             ext_bus_mode,
    // Pull-up enables
    output logic      [NPINS-1:0] pullup_on
);

    logic [NPINS-1:0] pullup_nxt;
    logic [NGRP-1:0]  grp_eff;

    // ------------------------------------------------------------------
    // Group gating
    // ------------------------------------------------------------------
    always_comb begin
        grp_eff = group_en;
        if (ext_bus_mode) begin
            grp_eff = group_en & ~NGRP'(`BUSPORT_GROUP_MASK);
        end
        for (int i = 0; i < NPINS; i++) begin
            pullup_nxt[i] = grp_eff[i/4] & ~drive_en[i];
        end
        pullup_nxt[`NMI_PIN_IDX] = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pullup_on <= '0;
        end else begin
            pullup_on <= pullup_nxt;
        end
    end

endmodule : gpio_pull_ctl

// ==== src/gpio_pin_drv.sv ====
`timescale 1ns/1ps
`include "gpio_bank_regs.svh"

module gpio_pin_drv #(
    parameter int NPINS = `NUM_PINS
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Settings
    input  wire logic [NPINS-1:0] dir,
    input  wire logic [NPINS-1:0] latch,
    input  wire logic [NPINS-1:0] per_sel,
    input  wire logic [NPINS-1:0] per_out,
    // Pins
    output logic      [NPINS-1:0] pin_o,
    output logic      [NPINS-1:0] pin_oe
);

    logic [NPINS-1:0] o_nxt;
    logic [NPINS-1:0] oe_nxt;

    // ------------------------------------------------------------------
    // Driver selection
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            oe_nxt[i] = dir[i] | per_sel[i];
            o_nxt[i]  = per_sel[i] ? per_out[i] : latch[i];
        end
        oe_nxt[`NMI_PIN_IDX] = 1'b0;
        o_nxt[`NMI_PIN_IDX]  = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_o  <= '0;
            pin_oe <= '0;
        end else begin
            pin_o  <= o_nxt;
            pin_oe <= oe_nxt;
        end
    end

endmodule : gpio_pin_drv

// ==== src/programmable_io_port_bank.sv ====
`timescale 1ns/1ps
`include "gpio_bank_regs.svh"

module programmable_io_port_bank #(
    parameter int NPINS = `NUM_PINS
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // AXI4-Lite write address
    input  wire logic [11:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    // AXI4-Lite write response
    output logic      [1:0]       s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    // AXI4-Lite read data
    output logic      [31:0]      s_axi_rdata,
    output logic      [1:0]       s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // Peripheral overrides
    input  wire logic [NPINS-1:0] per_sel,
    input  wire logic [NPINS-1:0] per_out,
    // Pins
    input  wire logic [NPINS-1:0] pin_i,
    output logic      [NPINS-1:0] pin_o,
    output logic      [NPINS-1:0] pin_oe,
    output logic      [NPINS-1:0] pullup_on
);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [95:0]  dir_r, dir_nxt;
    logic [95:0]  lat_r, lat_nxt;
    logic [21:0]  pull_r, pull_nxt;
    logic         rdlat_r, rdlat_nxt;
    logic [3:0]   mode_r, mode_nxt;
    logic [NPINS-1:0] pin_s_r;

    gpio_bank_pkg::bus_state_t wst_r, wst_nxt;
    gpio_bank_pkg::bus_state_t rst_r, rst_nxt;
    logic         aw_got_r, aw_got_nxt;
    logic         w_got_r, w_got_nxt;
    logic [11:0]  awa_r, awa_nxt;
    logic [31:0]  wd_r, wd_nxt;
    logic [3:0]   ws_r, ws_nxt;
    logic [1:0]   bresp_r, bresp_nxt;
    logic [31:0]  rdata_nxt;
    logic [1:0]   rresp_nxt;

    logic         ext_bus;
    logic         ctl_valid;
    logic [95:0]  pin_view;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic [1:0] word_idx(input logic [11:0] a);
        return a[3:2];
    endfunction : word_idx

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    always_comb begin
        ext_bus = (mode_r[1:0] == gpio_bank_pkg::MODE_MEM_EXPAND)
                | (mode_r[1:0] == gpio_bank_pkg::MODE_MICRO);
        ctl_valid = (ext_bus & mode_r[`MODE_BUS8_BIT])
                  | mode_r[`MODE_MUXALL_BIT];
    end

    // ------------------------------------------------------------------
    // Pin read path
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s_r <= '0;
        end else begin
            pin_s_r <= pin_i;
        end
    end

    always_comb begin
        pin_view = '0;
        for (int i = 0; i < NPINS; i++) begin
            pin_view[i] = (dir_r[i] | per_sel[i]) ? lat_r[i] : pin_s_r[i];
        end
        pin_view[`NMI_PIN_IDX] = pin_s_r[`NMI_PIN_IDX];
        if (ctl_valid && rdlat_r) begin
            pin_view[`SECOND_PORT_LSB +: 8] =
                lat_r[`SECOND_PORT_LSB +: 8];
        end else begin
            for (int i = 0; i < 8; i++) begin
                pin_view[`SECOND_PORT_LSB + i] =
                    dir_r[`SECOND_PORT_LSB + i]
                    ? lat_r[`SECOND_PORT_LSB + i]
                    : pin_s_r[`SECOND_PORT_LSB + i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    always_comb begin
        wst_nxt    = wst_r;
        aw_got_nxt = aw_got_r;
        w_got_nxt  = w_got_r;
        awa_nxt    = awa_r;
        wd_nxt     = wd_r;
        ws_nxt     = ws_r;
        bresp_nxt  = bresp_r;
        dir_nxt    = dir_r;
        lat_nxt    = lat_r;
        pull_nxt   = pull_r;
        rdlat_nxt  = rdlat_r;
        mode_nxt   = mode_r;
        case (wst_r)
            gpio_bank_pkg::ST_IDLE: begin
                if (s_axi_awvalid && !aw_got_r) begin
                    aw_got_nxt = 1'b1;
                    awa_nxt    = s_axi_awaddr;
                end
                if (s_axi_wvalid && !w_got_r) begin
                    w_got_nxt = 1'b1;
                    wd_nxt    = s_axi_wdata;
                    ws_nxt    = s_axi_wstrb;
                end
                if (aw_got_r && w_got_r) begin
                    bresp_nxt = 2'h0;
                    case (awa_r)
                        `OFS_DIR0, `OFS_DIR1, `OFS_DIR2: begin
                            dir_nxt[word_idx(awa_r)*32 +: 32] = merge(
                                dir_r[word_idx(awa_r)*32 +: 32],
                                wd_r, ws_r);
                        end
                        `OFS_LAT0, `OFS_LAT1, `OFS_LAT2: begin
                            lat_nxt[word_idx(awa_r)*32 +: 32] = merge(
                                lat_r[word_idx(awa_r)*32 +: 32],
                                wd_r, ws_r);
                        end
                        `OFS_PULLUP: begin
                            pull_nxt = 22'(merge(32'(pull_r), wd_r,
                                                 ws_r));
                        end
                        `OFS_PORTCTL: begin
                            if (ws_r[0]) begin
                                rdlat_nxt = wd_r[`PORTCTL_RDLATCH_BIT];
                            end
                        end
                        `OFS_MODE: begin
                            if (ws_r[0]) begin
                                mode_nxt = wd_r[3:0];
                            end
                        end
                        `OFS_PIN0, `OFS_PIN1, `OFS_PIN2: begin
                        end
                        default: begin
                            bresp_nxt = 2'h2;
                        end
                    endcase
                    dir_nxt[`NMI_PIN_IDX] = 1'b0;
                    dir_nxt[95:NPINS]     = '0;
                    lat_nxt[95:NPINS]     = '0;
                    aw_got_nxt = 1'b0;
                    w_got_nxt  = 1'b0;
                    wst_nxt    = gpio_bank_pkg::ST_RESP;
                end
            end
            gpio_bank_pkg::ST_RESP: begin
                if (s_axi_bready) begin
                    wst_nxt = gpio_bank_pkg::ST_IDLE;
                end
            end
            default: begin
                wst_nxt = gpio_bank_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_r    <= gpio_bank_pkg::ST_IDLE;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awa_r    <= 12'h000;
            wd_r     <= 32'h0000_0000;
            ws_r     <= 4'h0;
            bresp_r  <= 2'h0;
            dir_r    <= {3{`RST_DIR}};
            lat_r    <= {3{`RST_LAT}};
            pull_r   <= 22'(`RST_PULLUP);
            rdlat_r  <= 1'b0;
            mode_r   <= 4'(`RST_MODE);
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
        end else begin
            wst_r    <= wst_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r  <= w_got_nxt;
            awa_r    <= awa_nxt;
            wd_r     <= wd_nxt;
            ws_r     <= ws_nxt;
            bresp_r  <= bresp_nxt;
            dir_r    <= dir_nxt;
            lat_r    <= lat_nxt;
            pull_r   <= pull_nxt;
            rdlat_r  <= rdlat_nxt;
            mode_r   <= mode_nxt;
            s_axi_awready <= (wst_nxt == gpio_bank_pkg::ST_IDLE) & ~aw_got_nxt;
            s_axi_wready  <= (wst_nxt == gpio_bank_pkg::ST_IDLE) & ~w_got_nxt;
            s_axi_bvalid  <= (wst_nxt == gpio_bank_pkg::ST_RESP);
        end
    end

    assign s_axi_bresp = bresp_r;

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    always_comb begin
        rst_nxt   = rst_r;
        rdata_nxt = s_axi_rdata;
        rresp_nxt = s_axi_rresp;
        case (rst_r)
            gpio_bank_pkg::ST_IDLE: begin
                if (s_axi_arvalid) begin
                    rresp_nxt = 2'h0;
                    rdata_nxt = 32'h0000_0000;
                    case (s_axi_araddr)
                        `OFS_DIR0, `OFS_DIR1, `OFS_DIR2:
                            rdata_nxt =
                                dir_r[word_idx(s_axi_araddr)*32 +: 32];
                        `OFS_LAT0, `OFS_LAT1, `OFS_LAT2:
                            rdata_nxt =
                                lat_r[word_idx(s_axi_araddr)*32 +: 32];
                        `OFS_PIN0, `OFS_PIN1, `OFS_PIN2:
                            rdata_nxt =
                                pin_view[word_idx(s_axi_araddr)*32 +: 32];
                        `OFS_PULLUP:  rdata_nxt = 32'(pull_r);
                        `OFS_PORTCTL: rdata_nxt = 32'(rdlat_r);
                        `OFS_MODE:    rdata_nxt = 32'(mode_r);
                        `OFS_PERSEL0, `OFS_PERSEL1, `OFS_PERSEL2:
                            rdata_nxt = 32'(96'(per_sel)
                                >> (word_idx(s_axi_araddr) * 32));
                        default:      rresp_nxt = 2'h2;
                    endcase
                    rst_nxt = gpio_bank_pkg::ST_RESP;
                end
            end
            gpio_bank_pkg::ST_RESP: begin
                if (s_axi_rready) begin
                    rst_nxt = gpio_bank_pkg::ST_IDLE;
                end
            end
            default: begin
                rst_nxt = gpio_bank_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_r       <= gpio_bank_pkg::ST_IDLE;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end else begin
            rst_r       <= rst_nxt;
            s_axi_rdata <= rdata_nxt;
            s_axi_rresp <= rresp_nxt;
            s_axi_arready <= (rst_nxt == gpio_bank_pkg::ST_IDLE);
            s_axi_rvalid  <= (rst_nxt == gpio_bank_pkg::ST_RESP);
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers and pull-ups
    // ------------------------------------------------------------------
    gpio_pin_drv #(.NPINS(NPINS)) u_drv (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dir     (dir_r[NPINS-1:0]),
        .latch   (lat_r[NPINS-1:0]),
        .per_sel (per_sel),
        .per_out (per_out),
        .pin_o   (pin_o),
        .pin_oe  (pin_oe)
    );

    gpio_pull_ctl #(.NPINS(NPINS), .NGRP(`NUM_GROUPS)) u_pull (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .group_en     (pull_r),
        .drive_en     (dir_r[NPINS-1:0] | per_sel),
        .ext_bus_mode (ext_bus),
        .pullup_on    (pullup_on)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_nmi_no_dir: assert property (!dir_r[`NMI_PIN_IDX])
        else $error("nmi pin has a direction bit");
    a_nmi_no_drive: assert property (!pin_oe[`NMI_PIN_IDX] &&
        !pullup_on[`NMI_PIN_IDX]) else $error("nmi pin driven or pulled");
    a_out_no_pull: assert property (!(|(pin_oe & pullup_on)))
        else $error("pull on output pin");
    a_pull_follows: assert property (pull_r[0] && !ext_bus &&
        !dir_r[0] && !per_sel[0] |=> pullup_on[0])
        else $error("pull-up missing");
    a_bus_pull_off: assert property (ext_bus |=>
        !(|pullup_on[35:0]) && !(|pullup_on[47:40]))
        else $error("bus port pull active");
    a_drive_latch: assert property (dir_r[4] && !per_sel[4] |=>
        pin_oe[4] && pin_o[4] == $past(lat_r[4]))
        else $error("driver not following latch");
    a_rd_latch: assert property (ctl_valid && rdlat_r |->
        pin_view[15:8] == lat_r[15:8]) else $error("second port not latch");
    a_rd_pin: assert property (!(ctl_valid && rdlat_r) && !dir_r[8] |->
        pin_view[8] == pin_s_r[8]) else $error("second port input not pin");
    a_per_drive: assert property (per_sel[40] |=> pin_oe[40] &&
        pin_o[40] == $past(per_out[40]))
        else $error("peripheral override lost");

endmodule : programmable_io_port_bank

// ==== tb/pin_partner.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Devices outside the pins
// ----------------------------------------------------------------------
module pin_partner (
    // Design side
    input  wire logic [87:0] pin_o,
    input  wire logic [87:0] pin_oe,
    input  wire logic [87:0] pullup_on,
    // Outside drive where neither pin_oe nor a pull-up holds the line
    input  wire logic [87:0] ext_val,
    // Pin levels
    output logic      [87:0] pin_i
);
    always_comb begin
        for (int k = 0; k < 88; k++) begin
            pin_i[k] = pin_oe[k] ? pin_o[k] : (pullup_on[k] | ext_val[k]);
        end
    end
endmodule : pin_partner

// ==== tb/programmable_io_port_bank_bench.sv ====
`timescale 1ns/1ps
`include "gpio_bank_regs.svh"
module programmable_io_port_bank_bench;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] aw = 12'h000;
    logic [11:0] ar = 12'h000;
    logic [31:0] wd = 32'h0000_0000;
    logic        awv = 1'b0;
    logic        wv = 1'b0;
    logic        arv = 1'b0;
    logic        br = 1'b0;
    logic        rr = 1'b0;
    logic        awr, wr_r, arr, bv, rv;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [87:0] psel = 88'h0;
    logic [87:0] pout = 88'h0;
    logic [87:0] ext = 88'h0;
    logic [87:0] pin_i, pin_o, pin_oe, pull;
    logic [31:0] q;
    logic [1:0]  rs;
    int          mismatches = 0;
    int          total_checks = 0;
    always #5 aclk = ~aclk;
    programmable_io_port_bank uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .per_sel(psel),
        .per_out(pout), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .pullup_on(pull));
    pin_partner far (.pin_o(pin_o), .pin_oe(pin_oe), .pullup_on(pull),
        .ext_val(ext), .pin_i(pin_i));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (e !== g) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit ad, dd, ta, td, done;
        ad = 0; dd = 0; done = 0;
        @(posedge aclk);
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!(ad && dd)) begin
            @(negedge aclk);
            ta = awr && !ad;
            td = wr_r && !dd;
            @(posedge aclk);
            if (ta) begin ad = 1; awv <= 1'b0; end
            if (td) begin dd = 1; wv <= 1'b0; end
        end
        while (!done) begin
            @(negedge aclk);
            done = bv;
            rs = bresp;
            @(posedge aclk);
        end
        br <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        bit done, ta;
        done = 0;
        @(posedge aclk);
        ar <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ta = arr && arv;
            done = rv;
            q = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ta) arv <= 1'b0;
        end
        rr <= 1'b0;
    endtask : rd
    task automatic settle();
        repeat (3) @(posedge aclk);
        #1;
    endtask : settle
    task automatic t_reset();
        rd(`OFS_DIR0); chk("dir0", 32'h0, q);
        rd(`OFS_PULLUP); chk("pullup", 32'h0, q);
        chk("oe", 32'h0, pin_oe[31:0]);
        chk("pull", 32'h0, pull[31:0]);
    endtask : t_reset
    task automatic t_dir();
        wr(`OFS_LAT0, 32'h5A5A_5A5A);
        wr(`OFS_DIR0, 32'h0000_00F0);
        settle();
        chk("oe0", 32'h0000_00F0, pin_oe[31:0]);
        chk("out", 32'h5, pin_o[7:4]);
    endtask : t_dir
    task automatic t_nmi();
        wr(`OFS_DIR2, 32'hFFFF_FFFF);
        settle();
        chk("oe2", 32'hFF_FFDF, pin_oe[87:64]);
        wr(`OFS_DIR2, 32'h0);
        wr(`OFS_PULLUP, 32'h0002_0000);
        settle();
        chk("grp", 32'hD0, pull[71:64]);
        wr(`OFS_DIR2, 32'h0000_0040);
        settle();
        chk("grp_out", 32'h90, pull[71:64]);
    endtask : t_nmi
    task automatic t_ext();
        wr(`OFS_DIR0, 32'h0);
        wr(`OFS_DIR1, 32'h0);
        wr(`OFS_PULLUP, 32'h003F_FFFF);
        wr(`OFS_MODE, 32'h1);
        settle();
        chk("bus_pull", 32'h0, pull[31:0]);
        chk("port4_hi_pull", 32'hF0, pull[39:32]);
        chk("port5_pull", 32'h00, pull[47:40]);
        chk("port6_pull", 32'hFF, pull[55:48]);
        wr(`OFS_MODE, 32'h0);
        settle();
        chk("sc_pull", 32'hFFFF_FFFF, pull[31:0]);
    endtask : t_ext
    task automatic t_ctl();
        logic [3:0] m [6] = '{4'h0, 4'h5, 4'h7, 4'h8, 4'h4, 4'h5};
        logic       c [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        logic [7:0] e [6] = '{8'h05, 8'hA5, 8'hA5, 8'hA5, 8'h05, 8'h05};
        wr(`OFS_PULLUP, 32'h0);
        wr(`OFS_DIR0, 32'h0000_0F00);
        wr(`OFS_LAT0, 32'h0000_A500);
        ext[23:16] <= 8'h3C;
        for (int i = 0; i < 6; i++) begin
            wr(`OFS_MODE, {28'h0, m[i]});
            wr(`OFS_PORTCTL, {31'h0, c[i]});
            settle();
            rd(`OFS_PIN0);
            chk("port1", e[i], q[15:8]);
        end
        chk("pinread", 32'h3C, q[23:16]);
    endtask : t_ctl
    task automatic t_per();
        psel[40] <= 1'b1;
        pout[40] <= 1'b1;
        wr(`OFS_DIR1, 32'h0);
        settle();
        chk("per_oe", 32'h1, pin_oe[40]);
        chk("per_o", 32'h1, pin_o[40]);
        rd(`OFS_PERSEL1); chk("persel1", 32'h0000_0100, q);
        rd(12'hFFC); chk("rd_err", 32'h2, rs);
        wr(12'h0FC, 32'h1); chk("wr_err", 32'h2, rs);
    endtask : t_per
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #200us;
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_dir();
        t_nmi();
        t_ext();
        t_ctl();
        t_per();
        print_verdict();
    end
endmodule : programmable_io_port_bank_bench
